//--- adcc_analog_model.sv
// analog front end: comparator against the trial code
`timescale 1ns/1ns
module adcc_analog_model
  import adcc_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic [adcc_pkg::RES_W-1:0]        level,
  input  wire logic [adcc_pkg::RES_W-1:0]        dac_code,
  input  wire logic [adcc_pkg::NUM_AIN-1:0]      ain_select,
  input  wire logic                              high_reference,
  input  wire logic                              low_reference,
  output logic                                   cmp_above
);
  logic [RES_W-1:0] vin;
  logic             last = 1'b0;
  wire              linked = |ain_select | high_reference | low_reference;
  assign vin = high_reference ? '1 : (low_reference ? '0 : level);
  // isolated input floats: inverse of last answer, toggling every cycle
  assign cmp_above = linked ? (vin >= dac_code) : ~last;
  always @(posedge clk) last <= cmp_above;
endmodule : adcc_analog_model

//--- adcc_pkg.sv
// constants and types for the converter control block
package adcc_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;
  localparam int RES_W = 10;
  localparam int NUM_AIN = 28;
  localparam int CONV_DIV_DEF = 2;
  localparam int SAMPLE_TICKS_DEF = 4;

  localparam logic [ADR_W-1:0] OFS_CSR  = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CTL  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_RESH = 8'h08;
  localparam logic [ADR_W-1:0] OFS_RESL = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_CMPH = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CMPL = 8'h14;
  localparam logic [ADR_W-1:0] OFS_IST  = 8'h18;
  localparam logic [ADR_W-1:0] OFS_IMSK = 8'h1c;

  localparam int CSR_DONE  = 7;
  localparam int CSR_IEN   = 6;
  localparam int CSR_CONT  = 5;
  localparam int CHAN_MSB  = 4;
  localparam int CTL_ACT   = 7;
  localparam int CTL_TRIG  = 6;
  localparam int CTL_CMPEN = 5;
  localparam int CTL_CMPGT = 4;
  localparam int IST_DONE  = 0;
  localparam int IST_MISS  = 1;
  localparam int IST_W     = 2;

  localparam logic [4:0] CHAN_LAST_AIN = 5'h1b;
  localparam logic [4:0] CHAN_RSVD     = 5'h1c;
  localparam logic [4:0] CHAN_REFH     = 5'h1d;
  localparam logic [4:0] CHAN_REFL     = 5'h1e;
  localparam logic [4:0] CHAN_OFF      = 5'h1f;

  localparam logic [REG_W-1:0] CSR_RESET = 8'h1f;
  localparam logic [RES_W-1:0] RES_MSB   = 10'h200;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } adcc_state_type;
endpackage : adcc_pkg

//--- adcc_properties.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ns
module adcc_properties
  import adcc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        sample_hold,
  input wire logic        converter_power,
  input wire logic [27:0] ain_select,
  input wire logic        high_reference,
  input wire logic        low_reference,
  input wire logic [4:0]  mux_select
);
  wire req    = wb_cyc_i & wb_stb_i;
  wire wr_csr = req & wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_CSR);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  ack_answer_a: assert property ($rose(req) |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  chan_copy_a: assert property (wr_csr |=> ##1 mux_select == $past(wb_dat_i[4:0], 2))
    else $error("channel field not taken from write");
  one_input_a: assert property ($onehot0(ain_select))
    else $error("more than one input connected");
  off_power_a: assert property (wr_csr && wb_dat_i[4:0] == CHAN_OFF |=> ##1 !converter_power && ain_select == '0)
    else $error("converter still powered after off code");
  sample_power_a: assert property (sample_hold |-> converter_power)
    else $error("sampling while unpowered");
  refs_excl_a: assert property (high_reference |-> !low_reference && ain_select == '0)
    else $error("reference selected with another source");
  ain_power_a: assert property (|ain_select |-> converter_power)
    else $error("input connected while idle");
endmodule : adcc_properties

bind adcc_top adcc_properties chk (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .sample_hold(sample_hold), .converter_power(converter_power), .ain_select(ain_select),
  .high_reference(high_reference), .low_reference(low_reference), .mux_select(mux_select));

//--- adcc_top.sv
// converter control: register slave, trigger, sequencing and completion flag
`timescale 1ns/1ns

module adcc_top
  import adcc_pkg::*;
#(
  parameter int CONV_DIV     = adcc_pkg::CONV_DIV_DEF,
  parameter int SAMPLE_TICKS = adcc_pkg::SAMPLE_TICKS_DEF
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [adcc_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [adcc_pkg::DAT_W-1:0]    wb_dat_i,
  output logic      [adcc_pkg::DAT_W-1:0]    wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          hw_trigger_input,
  input  wire logic                          cmp_above,
  output logic      [adcc_pkg::RES_W-1:0]    dac_code,
  output logic                               sample_hold,
  output logic                               converter_power,
  output logic      [adcc_pkg::NUM_AIN-1:0]  ain_select,
  output logic                               high_reference,
  output logic                               low_reference,
  output logic      [4:0]                    mux_select,
  output logic                               irq
);
  import adcc_pkg::*;

  localparam int DIV_W = $clog2(CONV_DIV + 1);
  localparam int SMP_W = $clog2(SAMPLE_TICKS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
  localparam logic [SMP_W-1:0] SMP_LAST = SMP_W'(SAMPLE_TICKS - 1);

  // reset release
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // register state
  logic             done_flag;
  logic             done_irq_enable;
  logic             continuous_enable;
  logic [4:0]       channel_select;
  logic             trigger_select;
  logic             compare_enable;
  logic             compare_greater_select;
  logic [RES_W-1:0] compare_value;
  logic [RES_W-1:0] result;
  logic [IST_W-1:0] irq_status;
  logic [IST_W-1:0] irq_mask;

  // conversion state
  adcc_state_type   state;
  adcc_state_type   next_state;
  logic [DIV_W-1:0] div_cnt;
  logic [SMP_W-1:0] smp_cnt;
  logic [RES_W-1:0] trial;
  logic             cont_run;
  logic             next_cont_run;
  logic             hw_q;

  // bus decode; a request is taken at the edge where ack is high
  wire req     = wb_cyc_i & wb_stb_i;
  wire take    = req & wb_ack_o;
  wire wr      = take & wb_we_i & wb_sel_i[0];
  wire rd      = take & ~wb_we_i;
  wire wr_csr  = wr & (wb_adr_i == OFS_CSR);
  wire wr_ctl  = wr & (wb_adr_i == OFS_CTL);
  wire wr_cmph = wr & (wb_adr_i == OFS_CMPH);
  wire wr_cmpl = wr & (wb_adr_i == OFS_CMPL);
  wire wr_ist  = wr & (wb_adr_i == OFS_IST);
  wire wr_imsk = wr & (wb_adr_i == OFS_IMSK);
  wire rd_resl = rd & (wb_adr_i == OFS_RESL);

  wire       active = (state != ST_IDLE);
  wire [4:0] wr_chan = wb_dat_i[CHAN_MSB:0];
  wire [4:0] next_channel = wr_csr ? wr_chan : channel_select; // power, input and reference selects follow the write edge
  wire       chan_on = (next_channel != CHAN_OFF);

  // conversion tick and end of the last bit trial
  wire tick     = (div_cnt == DIV_LAST);
  wire conv_end = (state == ST_CONVERT) & tick & trial[0];
  wire [RES_W-1:0] kept = cmp_above ? dac_code : (dac_code & ~trial);

  // compare qualification
  wire cmp_true = compare_greater_select ? (kept >= compare_value)
                                         : (kept < compare_value);
  wire accept = conv_end & (~compare_enable | cmp_true);
  wire miss   = conv_end & compare_enable & ~cmp_true;

  // start sources
  wire hw_rise  = hw_trigger_input & ~hw_q;
  wire sw_start = wr_csr & ~trigger_select & (wr_chan != CHAN_OFF);
  wire hw_start = trigger_select & hw_rise & chan_on & ~active & ~wr_csr;
  wire restart  = conv_end & cont_run & continuous_enable & chan_on;
  wire start    = sw_start | hw_start | restart;

  // read mux
  wire [REG_W-1:0] csr_rd = {done_flag, done_irq_enable, continuous_enable, channel_select};
  wire [REG_W-1:0] ctl_rd = {active, trigger_select, compare_enable, compare_greater_select, 4'h0};
  wire [REG_W-1:0] rd_mux =
    (wb_adr_i == OFS_CSR)  ? csr_rd :
    (wb_adr_i == OFS_CTL)  ? ctl_rd :
    (wb_adr_i == OFS_RESH) ? REG_W'(result[RES_W-1:REG_W]) :
    (wb_adr_i == OFS_RESL) ? result[REG_W-1:0] :
    (wb_adr_i == OFS_CMPH) ? REG_W'(compare_value[RES_W-1:REG_W]) :
    (wb_adr_i == OFS_CMPL) ? compare_value[REG_W-1:0] :
    (wb_adr_i == OFS_IST)  ? REG_W'(irq_status) :
    (wb_adr_i == OFS_IMSK) ? REG_W'(irq_mask) :
    8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        wb_dat_o <= DAT_W'(rd_mux);
      end
    end
  end

  // control/status fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_irq_enable   <= CSR_RESET[CSR_IEN];
      continuous_enable <= CSR_RESET[CSR_CONT];
      channel_select    <= CSR_RESET[CHAN_MSB:0];
    end else if (wr_csr) begin
      done_irq_enable   <= wb_dat_i[CSR_IEN];
      continuous_enable <= wb_dat_i[CSR_CONT];
      channel_select    <= wr_chan;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_select         <= 1'b0;
      compare_enable         <= 1'b0;
      compare_greater_select <= 1'b0;
    end else if (wr_ctl) begin
      trigger_select         <= wb_dat_i[CTL_TRIG];
      compare_enable         <= wb_dat_i[CTL_CMPEN];
      compare_greater_select <= wb_dat_i[CTL_CMPGT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_value <= '0;
    end else begin
      if (wr_cmph) begin
        compare_value[RES_W-1:REG_W] <= wb_dat_i[RES_W-REG_W-1:0];
      end
      if (wr_cmpl) begin
        compare_value[REG_W-1:0] <= wb_dat_i[REG_W-1:0];
      end
    end
  end

  // completion: an accepted conversion wins over a clearing access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
      result    <= '0;
    end else begin
      if (accept) begin
        done_flag <= 1'b1;
      end else if (wr_csr | rd_resl) begin
        done_flag <= 1'b0;
      end
      if (accept) begin
        result <= kept;
      end
    end
  end

  // sticky event bits, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= (irq_status & ~(wr_ist ? wb_dat_i[IST_W-1:0] : '0))
                  | {miss, accept};
      if (wr_imsk) begin
        irq_mask <= wb_dat_i[IST_W-1:0];
      end
    end
  end

  // level request, held while flag and enable stay set or a masked event bit is set
  assign irq = (done_flag & done_irq_enable) | (|(irq_status & irq_mask));

  // continuous run: a CSR write always ends the old run
  always_comb begin
    if (sw_start) begin
      next_cont_run = wb_dat_i[CSR_CONT];
    end else if (wr_csr) begin
      next_cont_run = 1'b0;
    end else if (hw_start) begin
      next_cont_run = continuous_enable;
    end else if (conv_end & ~restart) begin
      next_cont_run = 1'b0;
    end else begin
      next_cont_run = cont_run;
    end
  end

  // sequencer
  always_comb begin
    next_state = state;
    if (wr_csr & ~sw_start) begin
      next_state = ST_IDLE;
    end else if (start) begin
      next_state = ST_SAMPLE;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_SAMPLE: begin
          if (tick && smp_cnt == SMP_LAST) begin
            next_state = ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (conv_end) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      cont_run <= 1'b0;
      hw_q     <= 1'b0;
    end else begin
      state    <= next_state;
      cont_run <= next_cont_run;
      hw_q     <= hw_trigger_input;
    end
  end

  // divider restarts with each conversion so every one has equal length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (start || tick || next_state == ST_IDLE) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt <= '0;
    end else if (start) begin
      smp_cnt <= '0;
    end else if (state == ST_SAMPLE && tick) begin
      smp_cnt <= smp_cnt + SMP_W'(1);
    end
  end

  // successive approximation, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code <= '0;
      trial    <= '0;
    end else if (state == ST_SAMPLE && next_state == ST_CONVERT) begin
      dac_code <= RES_MSB;
      trial    <= RES_MSB;
    end else if (state == ST_CONVERT && tick && !conv_end) begin
      dac_code <= kept | (trial >> 1);
      trial    <= trial >> 1;
    end
  end

  // analog side: powered and connected only while sampling or converting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_hold     <= 1'b0;
      converter_power <= 1'b0;
      ain_select      <= '0;
      high_reference  <= 1'b0;
      low_reference   <= 1'b0;
      mux_select      <= CSR_RESET[CHAN_MSB:0];
    end else begin
      sample_hold     <= (next_state == ST_SAMPLE);
      converter_power <= (next_state != ST_IDLE) & chan_on;
      ain_select      <= ((next_state != ST_IDLE) && next_channel <= CHAN_LAST_AIN)
                         ? (NUM_AIN'(1) << next_channel) : '0;
      high_reference  <= (next_state != ST_IDLE) & (next_channel == CHAN_REFH);
      low_reference   <= (next_state != ST_IDLE) & (next_channel == CHAN_REFL);
      mux_select      <= channel_select;
    end
  end

endmodule : adcc_top

//--- adcc_top_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module adcc_top_tb;
  import adcc_pkg::*;
  logic               clk = 0, nrst = 0, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, hw_trigger_input;
  logic [ADR_W-1:0]   wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [DAT_W-1:0]   wb_dat_i, wb_dat_o, rd;
  logic               cmp_above, sample_hold, converter_power, high_reference, low_reference;
  logic [RES_W-1:0]   dac_code, level, r;
  logic [NUM_AIN-1:0] ain_select;
  logic [4:0]         mux_select;
  int                 miscompares = 0, checks = 0, cycles = 0;

  adcc_top dut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .hw_trigger_input(hw_trigger_input), .cmp_above(cmp_above), .dac_code(dac_code),
    .sample_hold(sample_hold), .converter_power(converter_power), .ain_select(ain_select),
    .high_reference(high_reference), .low_reference(low_reference), .mux_select(mux_select), .irq(irq));
  adcc_analog_model model (.clk(clk), .level(level), .dac_code(dac_code), .ain_select(ain_select),
    .high_reference(high_reference), .low_reference(low_reference), .cmp_above(cmp_above));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // classic cycle: hold everything until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) miscompares++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'h1, d);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 4'h1, 32'h0);
  endtask : rdr

  task automatic wait_done();
    for (int n = 0; n < 20; n++) begin
      rdr(OFS_CSR);
      if (rd[CSR_DONE] === 1'b1) break;
    end
    if (rd[CSR_DONE] !== 1'b1) miscompares++;
  endtask : wait_done

  task automatic rd_res();
    rdr(OFS_RESH);
    r[9:8] = rd[1:0];
    rdr(OFS_RESL);
    r[7:0] = rd[7:0];
  endtask : rd_res

  task automatic t_regs();
    rdr(OFS_CSR);
    chk(rd, 32'h1f);
    rdr(OFS_CTL);
    chk(rd, 32'h0);
    rdr(8'h20);
    chk(rd, 32'h0);
    bus(1'b1, OFS_CSR, 4'h0, 32'hc3);
    rdr(OFS_CSR);
    chk(rd, 32'h1f);
  endtask : t_regs

  task automatic t_single();
    level <= 10'h2a5;
    wr(OFS_CSR, 32'h43);
    repeat (2) @(posedge clk);
    chk(ain_select, 28'h8);
    chk(mux_select, 5'h03);
    rdr(OFS_CTL);
    chk(rd, 32'h80);
    wr(OFS_CSR, 32'h43);
    wait_done();
    chk(rd, 32'hc3);
    chk(irq, 1'b1);
    rdr(OFS_CTL);
    chk(rd, 32'h0);
    rd_res();
    chk(r, 10'h2a5);
    chk({irq, ain_select}, 0);
    repeat (60) @(posedge clk);
    rdr(OFS_CSR);
    chk(rd, 32'h43);
  endtask : t_single

  task automatic t_refs();
    logic [4:0] code [3] = '{5'h1b, 5'h1d, 5'h1e};
    logic [9:0] exp [3] = '{10'h2a5, 10'h3ff, 10'h000};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CSR, {27'h0, code[i]});
      repeat (2) @(posedge clk);
      chk({ain_select[27], high_reference, low_reference}, 3'b100 >> i);
      wait_done();
      rd_res();
      chk(r, exp[i]);
    end
  endtask : t_refs

  task automatic t_compare();
    wr(OFS_CMPH, 32'h2);
    wr(OFS_CMPL, 32'h0);
    wr(OFS_CTL, 32'h20);
    wr(OFS_CSR, 32'h03);
    repeat (40) @(posedge clk);
    rdr(OFS_CSR);
    chk(rd, 32'h03);
    rd_res();
    chk(r, 10'h0);
    wr(OFS_CTL, 32'h30);
    wr(OFS_CSR, 32'h03);
    wait_done();
    chk(rd, 32'h83);
    rd_res();
    chk(r, 10'h2a5);
    wr(OFS_CTL, 32'h0);
  endtask : t_compare

  task automatic t_cont();
    wr(OFS_CSR, 32'h23);
    wait_done();
    rd_res();
    wait_done();
    chk(rd, 32'ha3);
    wr(OFS_CSR, 32'h3f);
    repeat (60) @(posedge clk);
    rdr(OFS_CSR);
    chk(rd, 32'h3f);
    chk(converter_power, 1'b0);
  endtask : t_cont

  task automatic t_hw();
    wr(OFS_CTL, 32'h40);
    wr(OFS_CSR, 32'h03);
    repeat (40) @(posedge clk);
    rdr(OFS_CSR);
    chk(rd, 32'h03);
    hw_trigger_input <= 1'b1;
    @(posedge clk);
    hw_trigger_input <= 1'b0;
    wait_done();
    chk(rd, 32'h83);
    wr(OFS_CTL, 32'h0);
  endtask : t_hw

  task automatic t_irq();
    rdr(OFS_IST);
    chk(rd, 32'h3);
    chk(irq, 1'b0);
    wr(OFS_IMSK, 32'h1);
    chk(irq, 1'b1);
    wr(OFS_IST, 32'h3);
    chk(irq, 1'b0);
    wr(OFS_IMSK, 32'h0);
  endtask : t_irq

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, hw_trigger_input} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, level} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_single();
    t_refs();
    t_compare();
    t_cont();
    t_hw();
    t_irq();
    wrap_up();
  end
endmodule : adcc_top_tb
